// >>> src/ppm_defs.vh
/*
 * constants of the port pin override mux: register indexes, field
 * positions, reset values and widths.
 * assumes: included by its bare name from the design file.
 */
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH

// widths
`define PPM_PINS           8
`define PPM_AW             4
`define PPM_DW             8

// register indexes on the plain register port
`define PPM_ADDR_OUT       4'h0
`define PPM_ADDR_DIR       4'h1
`define PPM_ADDR_PIN       4'h2
`define PPM_ADDR_CTRL      4'h3
`define PPM_ADDR_STAT      4'h4
`define PPM_ADDR_CLR       4'h5
`define PPM_ADDR_IEN       4'h6

// control register fields
`define PPM_CTRL_PUD       0
`define PPM_CTRL_LCD_DRIVE_ENABLE     1
`define PPM_CTRL_DUTY_LO   2
`define PPM_CTRL_DUTY_HI   3
`define PPM_CTRL_SENSE_LO  4
`define PPM_CTRL_SENSE_HI  5

// external interrupt sense encodings
`define PPM_SENSE_LEVEL    2'h0
`define PPM_SENSE_ANY      2'h1
`define PPM_SENSE_FALL     2'h2
`define PPM_SENSE_RISE     2'h3

// status / enable / clear fields
`define PPM_ST_EXTINT      0
`define PPM_ST_CHANGE      1
`define PPM_ST_W           2

// pin that carries the external interrupt
`define PPM_EXTINT_PIN     7

// reset values
`define PPM_RST_OUT        8'h00
`define PPM_RST_DIR        8'h00
`define PPM_RST_CTRL       6'h00
`define PPM_RST_STAT       2'h0
`define PPM_RST_IEN        2'h0
`define PPM_RST_SYNC       8'h00

`endif

// >>> src/ppm_port_pin_override_mux.v
/*
 * one eight-pin general purpose port with alternate function overrides,
 * deep sleep input clamp, an external interrupt on one pin and the lcd
 * backplane/frontplane mapping of the first port.
 * assumes: override enables and values come from the peripheral modules
 * on CLK; SLEEP comes from the sleep controller on CLK; PAD_IN and
 * ANALOG_PATH_I arrive from the pads asynchronously.
 * limits: the lcd drive lines are analog and are not muxed here; the
 * digital input to the alternate functions is raw and its consumer
 * synchronises it; the port read path has its own two flip-flops.
 * pull-ups follow the reset pin directly so they stay off in reset.
 */
`timescale 1ns/100ps
`include "ppm_defs.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - clamp digital input low during deep sleep
// - enabled external interrupt pin escapes the clamp
// - clamp release sets flag of disabled edge interrupt
// - all pull-ups off while reset active
// - pull-up from override, else dir/out/pud 010
// - driver enable from direction override or bit
// - driven value from value override or bit
// - toggle override inverts stored output bit
// - input enable from override, else sleep state
// - raw input to alternates, consumer synchronizes
// - analog path straight to pad, both ways
// - overrides come from owning peripheral modules
// - low pins backplanes, high pins frontplanes
// - lcd enable forces high pins off, segments
// - low pins forced per duty select, pin0 always
// - direction bit output, output bit pulls up
// - writing one to input bit toggles output
module ppm_port_pin_override_mux (
    // clock and reset
    input  wire                  CLK,
    input  wire                  RST_N,
    // register port
    input  wire [`PPM_AW-1:0]    ADDR,
    input  wire [`PPM_DW-1:0]    WDATA,
    input  wire                  WR,
    input  wire                  RD,
    output reg  [`PPM_DW-1:0]    RDATA,
    // interrupt
    output wire                  IRQ,
    // sleep controller
    input  wire                  SLEEP,
    // alternate function overrides, one bit per pin
    input  wire [`PPM_PINS-1:0]  PULLUP_OVERRIDE_EN,
    input  wire [`PPM_PINS-1:0]  PULLUP_OVERRIDE_VAL,
    input  wire [`PPM_PINS-1:0]  DIR_OVERRIDE_EN,
    input  wire [`PPM_PINS-1:0]  DIR_OVERRIDE_VAL,
    input  wire [`PPM_PINS-1:0]  VALUE_OVERRIDE_EN,
    input  wire [`PPM_PINS-1:0]  VALUE_OVERRIDE_VAL,
    input  wire [`PPM_PINS-1:0]  TOGGLE_OVERRIDE_EN,
    input  wire [`PPM_PINS-1:0]  INPUT_EN_OVERRIDE_EN,
    input  wire [`PPM_PINS-1:0]  INPUT_EN_OVERRIDE_VAL,
    // digital input to alternate functions
    output wire [`PPM_PINS-1:0]  ALT_DIGITAL_IN,
    // lcd drive lines
    input  wire [3:0]            BACKPLANE_LINES,
    input  wire [3:0]            FRONTPLANE_LINES,
    // analog path, three-signal form
    input  wire [`PPM_PINS-1:0]  ANALOG_PATH_I,
    output wire [`PPM_PINS-1:0]  ANALOG_PATH_O,
    output wire [`PPM_PINS-1:0]  ANALOG_PATH_OE,
    // pads
    input  wire [`PPM_PINS-1:0]  PAD_IN,
    output wire [`PPM_PINS-1:0]  PAD_OUT,
    output wire [`PPM_PINS-1:0]  PAD_OE,
    output wire [`PPM_PINS-1:0]  PAD_PULLUP
);

    //////////////////////////////////////////////////////////////////////////
    // state
    reg  [`PPM_PINS-1:0]  out_q;
    reg  [`PPM_PINS-1:0]  out_d;
    reg  [`PPM_PINS-1:0]  dir_q;
    reg  [5:0]            ctrl_q;
    reg  [`PPM_ST_W-1:0]  stat_q;
    reg  [`PPM_ST_W-1:0]  stat_d;
    reg  [`PPM_ST_W-1:0]  ien_q;
    reg  [`PPM_PINS-1:0]  sync1_q;
    reg  [`PPM_PINS-1:0]  sync2_q;
    reg  [`PPM_PINS-1:0]  prev_q;
    reg                   edge_hit;
    reg  [`PPM_DW-1:0]    rdata_d;

    wire                  pullup_global_disable;
    wire                  lcd_en;
    wire [1:0]            duty;
    wire [1:0]            sense;
    wire                  extint_en;
    wire [`PPM_PINS-1:0]  lcd_mask;
    wire [`PPM_PINS-1:0]  pu_oe;
    wire [`PPM_PINS-1:0]  pu_ov;
    wire [`PPM_PINS-1:0]  dd_oe;
    wire [`PPM_PINS-1:0]  dd_ov;
    wire [`PPM_PINS-1:0]  die_oe;
    wire [`PPM_PINS-1:0]  die_ov;
    wire [`PPM_PINS-1:0]  clamp_escape;
    wire [`PPM_PINS-1:0]  dig_in_en;
    wire [`PPM_PINS-1:0]  gated_in;
    wire                  ext_now;
    wire                  ext_was;
    reg  [3:0]            lcd_low;
    wire [`PPM_ST_W-1:0]  irq_src;

    // write strobes per register
    wire                  wr_out;
    wire                  wr_dir;
    wire                  wr_pin;
    wire                  wr_ctrl;
    wire                  wr_clr;
    wire                  wr_ien;
    genvar                gi;

    // interrupt pin event terms and the port change term
    wire                  low_hit;
    wire                  any_hit;
    wire                  fall_hit;
    wire                  rise_hit;
    wire                  any_change;

    //////////////////////////////////////////////////////////////////////////
    // control fields
    assign pullup_global_disable       = ctrl_q[`PPM_CTRL_PUD];
    assign lcd_en    = ctrl_q[`PPM_CTRL_LCD_DRIVE_ENABLE];
    assign duty      = ctrl_q[`PPM_CTRL_DUTY_HI:`PPM_CTRL_DUTY_LO];
    assign sense     = ctrl_q[`PPM_CTRL_SENSE_HI:`PPM_CTRL_SENSE_LO];
    assign extint_en = ien_q[`PPM_ST_EXTINT];

    //////////////////////////////////////////////////////////////////////////
    // write decode, one strobe per register
    assign wr_out  = WR && (ADDR == `PPM_ADDR_OUT);
    assign wr_dir  = WR && (ADDR == `PPM_ADDR_DIR);
    assign wr_pin  = WR && (ADDR == `PPM_ADDR_PIN);
    assign wr_ctrl = WR && (ADDR == `PPM_ADDR_CTRL);
    assign wr_clr  = WR && (ADDR == `PPM_ADDR_CLR);
    assign wr_ien  = WR && (ADDR == `PPM_ADDR_IEN);

    //////////////////////////////////////////////////////////////////////////
    // low pins taken per duty select, pin0 always
    always @* begin
        case (duty)
            2'h0:    lcd_low = 4'h1;
            2'h1:    lcd_low = 4'h3;
            2'h2:    lcd_low = 4'h7;
            default: lcd_low = 4'hf;
        endcase
    end

    // lcd takeover mask: high pins segments, low pins backplanes
    // pins 4 to 7 always go to the lcd while it is on
    assign lcd_mask[7:4] = {4{lcd_en}};
    assign lcd_mask[3:0] = {4{lcd_en}} & lcd_low;

    //////////////////////////////////////////////////////////////////////////
    // merge peripheral overrides with the lcd forced-off overrides
    assign pu_oe  = PULLUP_OVERRIDE_EN | lcd_mask;
    assign pu_ov  = PULLUP_OVERRIDE_VAL & ~lcd_mask;
    assign dd_oe  = DIR_OVERRIDE_EN | lcd_mask;
    assign dd_ov  = DIR_OVERRIDE_VAL & ~lcd_mask;
    assign die_oe = INPUT_EN_OVERRIDE_EN | lcd_mask;
    assign die_ov = INPUT_EN_OVERRIDE_VAL & ~lcd_mask;

    //////////////////////////////////////////////////////////////////////////
    // clamp escape for the enabled external interrupt pin
    // only that pin can escape; every other pin clamps in sleep unless its input enable is overridden
    assign clamp_escape = extint_en ? (8'h01 << `PPM_EXTINT_PIN) : 8'h00;

    //////////////////////////////////////////////////////////////////////////
    // per-pin mux: driver, value, pull-up and input enable
    generate
        for (gi = 0; gi < `PPM_PINS; gi = gi + 1) begin : g_pin
            wire drive_en;
            wire drive_val;
            wire pu_soft;
            wire pu_sel;
            wire in_soft;
            wire in_sel;
            // driver enable from direction override or bit
            assign drive_en  = dd_oe[gi] ? dd_ov[gi] : dir_q[gi];
            // driven value from value override or output bit
            assign drive_val = VALUE_OVERRIDE_EN[gi] ? VALUE_OVERRIDE_VAL[gi]
                                                     : out_q[gi];
            // software pull-up only on an input pin with output bit one
            assign pu_soft   = ~dir_q[gi] & out_q[gi] & ~pullup_global_disable;
            assign pu_sel    = pu_oe[gi] ? pu_ov[gi] : pu_soft;
            // input enable follows sleep unless the pin escapes the clamp
            assign in_soft   = ~SLEEP | clamp_escape[gi];
            assign in_sel    = die_oe[gi] ? die_ov[gi] : in_soft;
            // pin outputs; an undriven pin shows zero
            assign PAD_OE[gi]     = drive_en;
            assign PAD_OUT[gi]    = drive_en & drive_val;
            assign PAD_PULLUP[gi] = RST_N & pu_sel;
            assign dig_in_en[gi]  = in_sel;
        end
    endgenerate

    // disabled or clamped inputs read as zero
    assign gated_in       = PAD_IN & dig_in_en;
    assign ALT_DIGITAL_IN = gated_in;

    //////////////////////////////////////////////////////////////////////////
    // analog path: straight pad level out, enabled on the lcd pins
    assign ANALOG_PATH_O  = ANALOG_PATH_I;
    assign ANALOG_PATH_OE = lcd_mask;

    //////////////////////////////////////////////////////////////////////////
    // first synchronizer stage
    // pad level is asynchronous; two stages before any reader
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= `PPM_RST_SYNC;
        end else begin
            sync1_q <= gated_in;
        end
    end

    // second stage, the only reader of the first
    // keeps a metastable first stage away from the logic
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync2_q <= `PPM_RST_SYNC;
        end else begin
            sync2_q <= sync1_q;
        end
    end

    // previous synced value for edge detection
    // starts at the clamped level, so no false edge after reset
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_q <= `PPM_RST_SYNC;
        end else begin
            prev_q <= sync2_q;
        end
    end

    assign ext_now = sync2_q[`PPM_EXTINT_PIN];
    assign ext_was = prev_q[`PPM_EXTINT_PIN];

    // event terms of the interrupt pin and of the whole port
    assign low_hit    = ~ext_now;
    assign any_hit    = ext_now ^ ext_was;
    assign fall_hit   = ~ext_now & ext_was;
    assign rise_hit   = ext_now & ~ext_was;
    assign any_change = (sync2_q != prev_q);

    //////////////////////////////////////////////////////////////////////////
    // external interrupt detection, also while not enabled
    always @* begin
        case (sense)
            `PPM_SENSE_LEVEL: edge_hit = low_hit;
            `PPM_SENSE_ANY:   edge_hit = any_hit;
            `PPM_SENSE_FALL:  edge_hit = fall_hit;
            default:          edge_hit = rise_hit;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // next output bits: write, software toggle, override toggle
    // a write lands first so a toggle in the same cycle acts on it
    always @* begin
        out_d = out_q;
        if (wr_out) begin
            out_d = WDATA;
        end
        if (wr_pin) begin
            out_d = out_d ^ WDATA;
        end
        out_d = out_d ^ TOGGLE_OVERRIDE_EN;
    end

    //////////////////////////////////////////////////////////////////////////
    // sticky status: set wins over clear
    // an event in the clearing cycle must not be lost
    always @* begin
        stat_d = stat_q;
        if (wr_clr) begin
            stat_d = stat_q & ~WDATA[`PPM_ST_W-1:0];
        end
        if (edge_hit) begin
            stat_d[`PPM_ST_EXTINT] = 1'b1;
        end
        if (any_change) begin
            stat_d[`PPM_ST_CHANGE] = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // output bits and sticky status
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_q  <= `PPM_RST_OUT;
            stat_q <= `PPM_RST_STAT;
        end else begin
            out_q  <= out_d;
            stat_q <= stat_d;
        end
    end

    // direction bits, all inputs after reset
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dir_q <= `PPM_RST_DIR;
        end else if (wr_dir) begin
            dir_q <= WDATA;
        end
    end

    // control: pull-up disable, lcd enable, duty, sense
    // lcd stays off after reset so the pins start tri-stated
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `PPM_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_q <= WDATA[5:0];
        end
    end

    // interrupt enables
    // the enable also decides whether the interrupt pin escapes the clamp
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ien_q <= `PPM_RST_IEN;
        end else if (wr_ien) begin
            ien_q <= WDATA[`PPM_ST_W-1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read decode, unmapped reads zero
    always @* begin
        if (ADDR == `PPM_ADDR_OUT) begin
            rdata_d = out_q;
        end else if (ADDR == `PPM_ADDR_DIR) begin
            rdata_d = dir_q;
        end else if (ADDR == `PPM_ADDR_PIN) begin
            rdata_d = sync2_q;
        end else if (ADDR == `PPM_ADDR_CTRL) begin
            rdata_d = {2'h0, ctrl_q};
        end else if (ADDR == `PPM_ADDR_STAT) begin
            rdata_d = {6'h00, stat_q};
        end else if (ADDR == `PPM_ADDR_IEN) begin
            rdata_d = {6'h00, ien_q};
        end else begin
            rdata_d = 8'h00;
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_d;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // level interrupt from enabled sticky bits
    assign irq_src = stat_q & ien_q;
    assign IRQ     = |irq_src;

endmodule // ppm_port_pin_override_mux

// >>> testbench/ppm_periph.sv
/* ppm_periph: alternate function modules and pads around the mux.
   assumes: shares CLK with the mux; bench picks random or quiet. */
`timescale 1ns/100ps
module ppm_periph (
    // bench control
    input  logic       CLK,
    input  logic       rnd,
    input  logic [7:0] pad,
    input  logic [7:0] tgl,
    input  logic [7:0] alt_in,
    // overrides and pad levels
    output logic [7:0] pu_en = 8'h00,
    output logic [7:0] pu_val = 8'h00,
    output logic [7:0] dir_en = 8'h00,
    output logic [7:0] dir_val = 8'h00,
    output logic [7:0] val_en = 8'h00,
    output logic [7:0] val_val = 8'h00,
    output logic [7:0] in_en = 8'h00,
    output logic [7:0] in_val = 8'h00,
    output logic [7:0] tgl_en,
    output logic [7:0] pad_in = 8'h00,
    output logic [7:0] ana_in = 8'h00
);
    integer     seed = 32'h6919c686;
    logic [7:0] sync_q;
    logic [7:0] alt_q;
    function logic [7:0] rv;
        rv = rnd ? 8'($random(seed)) : 8'h00;
    endfunction
    //////////////////////////////////////////////////////////////////////
    // toggle requests pass straight through
    assign tgl_en = tgl;
    // each module owns its overrides, random while rnd is high
    always @(posedge CLK) begin
        pu_en <= rv();
        pu_val <= rv();
        dir_en <= rv();
        dir_val <= rv();
        val_en <= rv();
        val_val <= rv();
        in_en <= rv();
        in_val <= rv();
        pad_in <= rnd ? rv() : pad;
        ana_in <= rv();
    end
    // consumer resynchronises the raw input itself
    always @(posedge CLK) begin
        sync_q <= alt_in;
        alt_q <= sync_q;
    end
endmodule // ppm_periph

// >>> testbench/ppm_sva.sv
/* ppm_sva: pin, override and lcd checks for the port pin mux.
   assumes: bound into the mux top, one clock, async active-low reset. */
`timescale 1ns/100ps
module ppm_sva (
    // clock and reset
    input logic       CLK,
    input logic       RST_N,
    input logic       SLEEP,
    // override inputs
    input logic [7:0] PULLUP_OVERRIDE_EN,
    input logic [7:0] PULLUP_OVERRIDE_VAL,
    input logic [7:0] DIR_OVERRIDE_EN,
    input logic [7:0] DIR_OVERRIDE_VAL,
    input logic [7:0] VALUE_OVERRIDE_EN,
    input logic [7:0] VALUE_OVERRIDE_VAL,
    input logic [7:0] INPUT_EN_OVERRIDE_EN,
    input logic [7:0] INPUT_EN_OVERRIDE_VAL,
    // pad side
    input logic [7:0] ALT_DIGITAL_IN,
    input logic [7:0] ANALOG_PATH_I,
    input logic [7:0] ANALOG_PATH_O,
    input logic [7:0] ANALOG_PATH_OE,
    input logic [7:0] PAD_IN,
    input logic [7:0] PAD_OUT,
    input logic [7:0] PAD_OE,
    input logic [7:0] PAD_PULLUP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    //////////////////////////////////////////////////////////////////////
    // pull-up, driver and value overrides
    pullup_in_reset_a: assert property (disable iff (1'b0) !RST_N |-> PAD_PULLUP == 8'h00)
        else $error("pull-up on in reset");
    pullup_override_a: assert property (((PAD_PULLUP ^ PULLUP_OVERRIDE_VAL) & PULLUP_OVERRIDE_EN & ~ANALOG_PATH_OE) == 8'h00)
        else $error("pull-up override lost");
    dir_override_a: assert property (((PAD_OE ^ DIR_OVERRIDE_VAL) & DIR_OVERRIDE_EN & ~ANALOG_PATH_OE) == 8'h00)
        else $error("driver override lost");
    value_override_a: assert property (((PAD_OUT ^ VALUE_OVERRIDE_VAL) & PAD_OE & VALUE_OVERRIDE_EN) == 8'h00)
        else $error("value override lost");
    undriven_low_a: assert property ((PAD_OUT & ~PAD_OE) == 8'h00)
        else $error("value on undriven pin");
    // input enable and clamp
    sleep_clamp_a: assert property (SLEEP && INPUT_EN_OVERRIDE_EN == 8'h00 |-> ALT_DIGITAL_IN[6:0] == 7'h00)
        else $error("input not clamped");
    input_override_a: assert property (((ALT_DIGITAL_IN ^ (PAD_IN & INPUT_EN_OVERRIDE_VAL)) & INPUT_EN_OVERRIDE_EN & ~ANALOG_PATH_OE) == 8'h00)
        else $error("input override lost");
    gated_input_a: assert property ((ALT_DIGITAL_IN & ~PAD_IN) == 8'h00)
        else $error("input seen high on low pad");
    analog_path_a: assert property (ANALOG_PATH_O == ANALOG_PATH_I)
        else $error("analog path gated");
    // lcd takeover
    lcd_takeover_a: assert property ((ANALOG_PATH_OE & (PAD_OE | PAD_PULLUP | ALT_DIGITAL_IN)) == 8'h00)
        else $error("lcd pin not released");
    lcd_duty_a: assert property ($rose(ANALOG_PATH_OE[1]) |-> ANALOG_PATH_OE[0] && &ANALOG_PATH_OE[7:4])
        else $error("lcd duty order broken");
    // main scenarios reached
    cover property (SLEEP && ALT_DIGITAL_IN[7]);
    cover property (ANALOG_PATH_OE == 8'hff);
    cover property (|(PAD_PULLUP & ~PULLUP_OVERRIDE_EN));
endmodule // ppm_sva

// >>> testbench/tb_port_pin_override_mux.sv
/* tb_port_pin_override_mux: self-checking bench for the port pin mux.
   assumes: ppm_periph drives the far side; ppm_sva is bound below. */
`timescale 1ns/100ps
module tb_port_pin_override_mux;
    logic       CLK = 0, RST_N = 0, WR = 0, RD = 0, SLEEP = 0, rnd = 1, pullup_global_disable;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00, pad = 8'h00, tgl = 8'h00, rdv, dir, o, m, RDATA, alt;
    logic [7:0] pu_en, pu_val, dir_en, dir_val, val_en, val_val, in_en, in_val;
    logic [7:0] tgl_en, pad_in, ana_in, aoe, PAD_OUT, PAD_OE, PAD_PULLUP, ie, oe;
    logic       IRQ;
    integer     seed = 32'h6919c686, miscompares = 0, total_checks = 0;
    ppm_port_pin_override_mux DUT (.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
        .SLEEP, .PULLUP_OVERRIDE_EN(pu_en), .PULLUP_OVERRIDE_VAL(pu_val),
        .DIR_OVERRIDE_EN(dir_en), .DIR_OVERRIDE_VAL(dir_val), .VALUE_OVERRIDE_EN(val_en),
        .VALUE_OVERRIDE_VAL(val_val), .TOGGLE_OVERRIDE_EN(tgl_en),
        .INPUT_EN_OVERRIDE_EN(in_en), .INPUT_EN_OVERRIDE_VAL(in_val), .ALT_DIGITAL_IN(alt),
        .BACKPLANE_LINES(4'h0), .FRONTPLANE_LINES(4'h0), .ANALOG_PATH_I(ana_in),
        .ANALOG_PATH_O(), .ANALOG_PATH_OE(aoe), .PAD_IN(pad_in), .PAD_OUT, .PAD_OE,
        .PAD_PULLUP);
    ppm_periph u_periph (.CLK, .rnd, .pad, .tgl, .alt_in(alt), .pu_en, .pu_val, .dir_en,
        .dir_val, .val_en, .val_val, .in_en, .in_val, .tgl_en, .pad_in, .ana_in);
    //////////////////////////////////////////////////////////////////////
    // clock, compare and bus tasks
    always #5 CLK = ~CLK;
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %0s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge CLK);
        RD <= 1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 0;
        @(negedge CLK);
        rdv = RDATA;
    endtask
    task finish_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // runs far past the expected span of about 15 us
    initial begin
        #300000;
        miscompares++;
        finish_test;
    end
    //////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge CLK);
        @(negedge CLK);
        chk("pullup_rst", 8'h00, PAD_PULLUP);
        @(posedge CLK);
        RST_N <= 1;
        rnd <= 0;
        repeat (4) @(posedge CLK);
        wr(5, 8'h03);
        for (int a = 0; a < 8; a++) begin
            rd(a == 7 ? 4'hf : 4'(a));
            chk("reset_read", a == 4 ? 8'h01 : 8'h00, rdv);
        end
        wr(1, 8'h5a);
        wr(4'hf, 8'hff);
        rd(1);
        chk("dir_rw", 8'h5a, rdv);
        $display("test registers done");
        rnd <= 1;
        for (int i = 0; i < 200; i++) begin
            dir = 8'($random(seed));
            o = 8'($random(seed));
            pullup_global_disable = 1'($random(seed));
            wr(1, dir);
            wr(0, o);
            wr(3, {7'h00, pullup_global_disable});
            @(posedge CLK);
            SLEEP <= 1'($random(seed));
            @(negedge CLK);
            oe = (dir_en & dir_val) | (~dir_en & dir);
            ie = (in_en & in_val) | (~in_en & {8{~SLEEP}});
            chk("pad_oe", oe, PAD_OE);
            chk("pad_out", oe & ((val_en & val_val) | (~val_en & o)), PAD_OUT);
            chk("pullup", (pu_en & pu_val) | (~pu_en & ~dir & o & {8{~pullup_global_disable}}), PAD_PULLUP);
            chk("alt_in", pad_in & ie, alt);
        end
        rnd <= 0;
        SLEEP <= 0;
        $display("test random done");
        wr(0, 8'h0f);
        wr(2, 8'h3c);
        rd(0);
        chk("out_pin_write", 8'h33, rdv);
        tgl <= 8'h01;
        @(posedge CLK);
        tgl <= 8'h00;
        rd(0);
        chk("out_toggle", 8'h32, rdv);
        wr(1, 8'hff);
        for (int d = 0; d < 4; d++) begin
            wr(3, {4'h0, 2'(d), 2'b10});
            @(negedge CLK);
            m = 8'hf0 | ((8'h02 << d) - 8'h01);
            chk("lcd_mask", m, aoe);
            chk("lcd_oe", ~m, PAD_OE);
        end
        $display("test lcd done");
        wr(3, 8'h30);
        wr(1, 8'h00);
        wr(0, 8'hff);
        @(negedge CLK);
        chk("unused_pullup", 8'hff, PAD_PULLUP);
        SLEEP <= 1;
        pad <= 8'hff;
        wr(5, 8'h03);
        @(negedge CLK);
        chk("clamp", 8'h00, alt);
        @(posedge CLK);
        SLEEP <= 0;
        repeat (4) @(posedge CLK);
        rd(4);
        chk("wake_flag", 8'h01, rdv & 8'h01);
        chk("irq_masked", 8'h00, {7'h00, IRQ});
        wr(6, 8'h01);
        @(negedge CLK);
        chk("irq_on", 8'h01, {7'h00, IRQ});
        wr(5, 8'h03);
        @(negedge CLK);
        chk("irq_cleared", 8'h00, {7'h00, IRQ});
        @(posedge CLK);
        SLEEP <= 1;
        @(negedge CLK);
        chk("escape", 8'h80, alt);
        $display("test sleep done");
        finish_test;
    end
endmodule // tb_port_pin_override_mux
bind ppm_port_pin_override_mux ppm_sva u_sva (.CLK, .RST_N, .SLEEP, .PULLUP_OVERRIDE_EN,
    .PULLUP_OVERRIDE_VAL, .DIR_OVERRIDE_EN, .DIR_OVERRIDE_VAL, .VALUE_OVERRIDE_EN,
    .VALUE_OVERRIDE_VAL, .INPUT_EN_OVERRIDE_EN, .INPUT_EN_OVERRIDE_VAL, .ALT_DIGITAL_IN,
    .ANALOG_PATH_I, .ANALOG_PATH_O, .ANALOG_PATH_OE, .PAD_IN, .PAD_OUT, .PAD_OE, .PAD_PULLUP);
